/* File: logic/ebp_pkg.sv */
// constants and types shared by the external bus pin block
package ebp_pkg;
    // register byte offsets on the apb bus
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_ADDR = 12'h004;
    localparam logic [11:0] OFF_WDATA = 12'h008;
    localparam logic [11:0] OFF_CMD = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010;
    localparam logic [11:0] OFF_RDATA = 12'h014;
    // control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_WEN_BIT = 1;
    localparam int CTRL_MODE_LSB = 4;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // command register fields
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_WR_BIT = 1;
    localparam int CMD_BE_LSB = 2;
    // status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CFGP_BIT = 1;
    // widths and reset values
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int PIN_W = 32;
    localparam int NIBBLES = 8;
    localparam logic [19:0] ADDR_RESET = 20'h0_0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [31:0] PIN_RESET = 32'h0000_0000;
    localparam logic [3:0] MODE_PROHIBITED = 4'hf;
    // role of one group of four pins
    localparam logic [1:0] ROLE_NONE = 2'h0;
    localparam logic [1:0] ROLE_ADDR = 2'h1;
    localparam logic [1:0] ROLE_DATA = 2'h2;
    localparam logic [1:0] ROLE_MUX = 2'h3;
    // bus cycle states, gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_STRB = 3'b011,
        ST_DONE = 3'b010
    } ebp_state_t;
endpackage

/* File: logic/ebp_ext_bus.sv */
// external memory bus pin configuration and bus cycle engine
// Notes on behaviour
// [R1] pin functions follow mode select, interface enable and wait enable
// [R2] unassigned pins, or all pins when disabled, are released as port pins
// [R3] mode 0000 drives only pins 7-0 as muxed address/data 7-0
// [R4] modes 0001-0011 add address nibbles 11-8, 15-12, 19-16 on same pins
// [R5] mode 0100 gives 16-bit data, pins 15-8 data, pins 7-0 muxed
// [R6] modes 0101-0111 mux pins 11-8, then 15-12; 0111 adds address 19-16
// [R7] separate 8-bit modes: data 7-0, then address nibbles from pin 8 up
// [R8] separate 16-bit modes: data 15-0, then address nibbles from pin 16 up
// [R9] software never selects mode 1111; it owns no pins here
// [R10] while enabled, bus clock and read strobe are always driven
// [R11] address strobe driven only in multiplexed modes (upper mode bit 0)
// [R12] second mode bit 0: one write strobe; 1: low and high byte strobes
// [R13] wait enabled and interface on: wait pin is a dedicated input
// [R14] bus clock output runs at half the link clock
// [R15] external party latches address with address strobe before data
// [R16] byte write on 16-bit bus asserts only the addressed lane strobe
// [R17] during wait, strobes, address and data hold; wait rechecked each clock
`timescale 1ns/1ps
module ebp_ext_bus (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_link,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] extPinIn,
    output logic [31:0] extPinOut,
    output logic [31:0] extPinOe,
    output logic [31:0] extPinOwned,
    output logic busClockOutput,
    output logic busClockOe,
    output logic addressLatchStrobe,
    output logic addressLatchStrobeOe,
    output logic readStrobeN,
    output logic readStrobeOe,
    output logic writeStrobeLowN,
    output logic writeStrobeLowOe,
    output logic writeStrobeHighN,
    output logic writeStrobeHighOe,
    input wire logic waitPinN,
    output logic waitPinDedicated
);
    // role and index of one pin nibble for a mode
    function automatic logic [4:0] pinRole(input logic [3:0] mode, input logic [2:0] n);
        logic [3:0] cnt;
        logic [3:0] nn;
        cnt = {2'b00, mode[1:0]};
        nn = {1'b0, n};
        pinRole = {ebp_pkg::ROLE_NONE, 3'd0};
        case (mode[3:2])
            // [R3] [R4] muxed 8-bit layouts
            2'b00: begin
                if (nn < 4'd2) begin
                    pinRole = {ebp_pkg::ROLE_MUX, n};
                end else if (nn <= 4'd1 + cnt) begin
                    pinRole = {ebp_pkg::ROLE_ADDR, n};
                end
            end
            // [R5] [R6] muxed 16-bit layouts
            2'b01: begin
                if (nn < 4'd2) begin
                    pinRole = {ebp_pkg::ROLE_MUX, n};
                end else if (nn == 4'd2) begin
                    pinRole = {(mode[1:0] != 2'b00) ? ebp_pkg::ROLE_MUX : ebp_pkg::ROLE_DATA, n};
                end else if (nn == 4'd3) begin
                    pinRole = {mode[1] ? ebp_pkg::ROLE_MUX : ebp_pkg::ROLE_DATA, n};
                end else if (nn == 4'd4 && mode[1:0] == 2'b11) begin
                    pinRole = {ebp_pkg::ROLE_ADDR, n};
                end
            end
            // [R7] separate 8-bit layouts
            2'b10: begin
                if (nn < 4'd2) begin
                    pinRole = {ebp_pkg::ROLE_DATA, n};
                end else if (nn <= 4'd3 + cnt) begin
                    pinRole = {ebp_pkg::ROLE_ADDR, 3'(n - 3'd2)};
                end
            end
            // [R8] [R9] separate 16-bit layouts, prohibited mode owns nothing
            default: begin
                if (mode == ebp_pkg::MODE_PROHIBITED) begin
                    pinRole = {ebp_pkg::ROLE_NONE, 3'd0};
                end else if (nn < 4'd4) begin
                    pinRole = {ebp_pkg::ROLE_DATA, n};
                end else if (nn <= 4'd5 + cnt) begin
                    pinRole = {ebp_pkg::ROLE_ADDR, 3'(n - 3'd4)};
                end
            end
        endcase
    endfunction

    function automatic logic isMapped(input logic [11:0] a);
        isMapped = (a == ebp_pkg::OFF_CTRL) || (a == ebp_pkg::OFF_ADDR) || (a == ebp_pkg::OFF_WDATA)
            || (a == ebp_pkg::OFF_CMD) || (a == ebp_pkg::OFF_STATUS) || (a == ebp_pkg::OFF_RDATA);
    endfunction

    // system clock side state
    logic [5:0] cfgS_q;
    logic cfgTgl_q;
    logic [19:0] addrS_q;
    logic [15:0] wdataS_q;
    logic wrS_q;
    logic [1:0] beS_q;
    logic cmdTgl_q;
    logic [15:0] rdS_q;
    logic cfgAckS1_q, cfgAckS2_q;
    logic doneS1_q, doneS2_q, doneS3_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic busyS, cfgPendS, apbWrite, apbAccess;
    logic [31:0] readMux;

    // link side state
    logic rstLinkS1_q, rstLinkN_q;
    logic cfgS1_q, cfgS2_q, cfgS3_q;
    logic cmdS1_q, cmdS2_q, cmdS3_q;
    logic waitS1_q, waitS2_q;
    logic [31:0] pinS1_q, pinS2_q;
    logic [5:0] cfgL_q;
    logic cfgAckTgl_q;
    ebp_pkg::ebp_state_t state_q;
    logic [19:0] addrL_q;
    logic [15:0] wdataL_q;
    logic wrL_q;
    logic [1:0] beL_q;
    logic doneTgl_q;
    logic [15:0] rdL_q;
    logic [15:0] rdNext;
    logic [4:0] role [ebp_pkg::NIBBLES];
    logic [31:0] aW, dW;
    logic [31:0] pinOut_q, pinOe_q, pinOwned_q;
    logic busClk_q, busClkOe_q, alStb_q, alStbOe_q, rdN_q, rdOe_q;
    logic wrLowN_q, wrLowOe_q, wrHighN_q, wrHighOe_q, waitDed_q;
    logic en, waitEn, tick, waitActive, cmdEdge, inStrb;
    logic [3:0] mode;

    assign busyS = cmdTgl_q != doneS2_q;
    assign cfgPendS = cfgTgl_q != cfgAckS2_q;
    assign apbAccess = psel && penable && !pready_q;
    assign apbWrite = psel && penable && pwrite && pready_q;

    always_comb begin
        readMux = 32'h0000_0000;
        case (paddr)
            ebp_pkg::OFF_CTRL: readMux = {24'h00_0000, cfgS_q[5:2], 2'b00, cfgS_q[1:0]};
            ebp_pkg::OFF_ADDR: readMux = {12'h000, addrS_q};
            ebp_pkg::OFF_WDATA: readMux = {16'h0000, wdataS_q};
            ebp_pkg::OFF_CMD: readMux = {28'h000_0000, beS_q, wrS_q, 1'b0};
            ebp_pkg::OFF_STATUS: readMux = {30'h0000_0000, cfgPendS, busyS};
            ebp_pkg::OFF_RDATA: readMux = {16'h0000, rdS_q};
            default: readMux = 32'h0000_0000;
        endcase
    end

    // apb answer in the second access cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= ebp_pkg::PIN_RESET;
        end else begin
            pready_q <= apbAccess;
            pslverr_q <= apbAccess && !isMapped(paddr);
            if (apbAccess) begin
                prdata_q <= pwrite ? ebp_pkg::PIN_RESET : readMux;
            end
        end
    end

    // [R1] software configuration, held while crossing
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfgS_q <= ebp_pkg::CTRL_RESET;
            cfgTgl_q <= 1'b0;
        end else if (apbWrite && paddr == ebp_pkg::OFF_CTRL && !cfgPendS) begin
            cfgS_q <= {pwdata[ebp_pkg::CTRL_MODE_LSB +: 4], pwdata[ebp_pkg::CTRL_WEN_BIT],
                pwdata[ebp_pkg::CTRL_EN_BIT]};
            cfgTgl_q <= ~cfgTgl_q;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            addrS_q <= ebp_pkg::ADDR_RESET;
            wdataS_q <= ebp_pkg::DATA_RESET;
            wrS_q <= 1'b0;
            beS_q <= 2'b00;
            cmdTgl_q <= 1'b0;
        end else if (apbWrite && !busyS) begin
            if (paddr == ebp_pkg::OFF_ADDR) begin
                addrS_q <= pwdata[ebp_pkg::ADDR_W-1:0];
            end
            if (paddr == ebp_pkg::OFF_WDATA) begin
                wdataS_q <= pwdata[ebp_pkg::DATA_W-1:0];
            end
            if (paddr == ebp_pkg::OFF_CMD) begin
                wrS_q <= pwdata[ebp_pkg::CMD_WR_BIT];
                beS_q <= pwdata[ebp_pkg::CMD_BE_LSB +: 2];
                cmdTgl_q <= cmdTgl_q ^ pwdata[ebp_pkg::CMD_GO_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfgAckS1_q <= 1'b0;
            cfgAckS2_q <= 1'b0;
            doneS1_q <= 1'b0;
            doneS2_q <= 1'b0;
            doneS3_q <= 1'b0;
            rdS_q <= ebp_pkg::DATA_RESET;
        end else begin
            cfgAckS1_q <= cfgAckTgl_q;
            cfgAckS2_q <= cfgAckS1_q;
            doneS1_q <= doneTgl_q;
            doneS2_q <= doneS1_q;
            doneS3_q <= doneS2_q;
            if (doneS2_q != doneS3_q) begin
                rdS_q <= rdL_q;
            end
        end
    end

    // link domain reset release
    always_ff @(posedge clk_link or negedge resetn) begin
        if (!resetn) begin
            rstLinkS1_q <= 1'b0;
            rstLinkN_q <= 1'b0;
        end else begin
            rstLinkS1_q <= 1'b1;
            rstLinkN_q <= rstLinkS1_q;
        end
    end

    always_ff @(posedge clk_link or negedge rstLinkN_q) begin
        if (!rstLinkN_q) begin
            {cfgS1_q, cfgS2_q, cfgS3_q} <= 3'b000;
            {cmdS1_q, cmdS2_q, cmdS3_q} <= 3'b000;
            {waitS1_q, waitS2_q} <= 2'b11;
            pinS1_q <= ebp_pkg::PIN_RESET;
            pinS2_q <= ebp_pkg::PIN_RESET;
        end else begin
            {cfgS1_q, cfgS2_q, cfgS3_q} <= {cfgTgl_q, cfgS1_q, cfgS2_q};
            {cmdS1_q, cmdS2_q, cmdS3_q} <= {cmdTgl_q, cmdS1_q, cmdS2_q};
            {waitS1_q, waitS2_q} <= {waitPinN, waitS1_q};
            pinS1_q <= extPinIn;
            pinS2_q <= pinS1_q;
        end
    end

    always_ff @(posedge clk_link or negedge rstLinkN_q) begin
        if (!rstLinkN_q) begin
            cfgL_q <= ebp_pkg::CTRL_RESET;
            cfgAckTgl_q <= 1'b0;
        end else if (cfgS2_q != cfgS3_q) begin
            cfgL_q <= cfgS_q;
            cfgAckTgl_q <= cfgS2_q;
        end
    end

    assign en = cfgL_q[0];
    assign waitEn = cfgL_q[1];
    assign mode = cfgL_q[5:2];
    assign tick = busClk_q;
    assign cmdEdge = cmdS2_q != cmdS3_q;
    assign inStrb = state_q == ebp_pkg::ST_STRB;
    // [R13] wait is active low and only counts when dedicated
    assign waitActive = en && waitEn && !waitS2_q;
    assign aW = {12'h000, addrL_q};
    assign dW = {16'h0000, wdataL_q};

    always_comb begin
        rdNext = ebp_pkg::DATA_RESET;
        for (int n = 0; n < ebp_pkg::NIBBLES; n++) begin
            role[n] = pinRole(mode, 3'(n));
            if (role[n][4:3] == ebp_pkg::ROLE_DATA || role[n][4:3] == ebp_pkg::ROLE_MUX) begin
                rdNext[{role[n][1:0], 2'b00} +: 4] = pinS2_q[4*n +: 4];
            end
        end
    end

    // [R14] bus clock is the link clock divided by two
    always_ff @(posedge clk_link or negedge rstLinkN_q) begin
        if (!rstLinkN_q) begin
            busClk_q <= 1'b0;
        end else begin
            busClk_q <= en ? ~busClk_q : 1'b0;
        end
    end

    always_ff @(posedge clk_link or negedge rstLinkN_q) begin
        if (!rstLinkN_q) begin
            state_q <= ebp_pkg::ST_IDLE;
            addrL_q <= ebp_pkg::ADDR_RESET;
            wdataL_q <= ebp_pkg::DATA_RESET;
            wrL_q <= 1'b0;
            beL_q <= 2'b00;
            doneTgl_q <= 1'b0;
            rdL_q <= ebp_pkg::DATA_RESET;
        end else begin
            case (state_q)
                ebp_pkg::ST_IDLE: begin
                    if (cmdEdge) begin
                        addrL_q <= addrS_q;
                        wdataL_q <= wdataS_q;
                        wrL_q <= wrS_q;
                        beL_q <= beS_q;
                        state_q <= en ? ebp_pkg::ST_ADDR : ebp_pkg::ST_DONE;
                    end
                end
                ebp_pkg::ST_ADDR: begin
                    if (!en) begin
                        state_q <= ebp_pkg::ST_DONE;
                    end else if (tick) begin
                        state_q <= ebp_pkg::ST_STRB;
                    end
                end
                // [R17] stay in strobe phase while wait is seen at a bus clock
                ebp_pkg::ST_STRB: begin
                    if (!en) begin
                        state_q <= ebp_pkg::ST_DONE;
                    end else if (tick && !waitActive) begin
                        rdL_q <= wrL_q ? ebp_pkg::DATA_RESET : rdNext;
                        state_q <= ebp_pkg::ST_DONE;
                    end
                end
                ebp_pkg::ST_DONE: begin
                    doneTgl_q <= ~doneTgl_q;
                    state_q <= ebp_pkg::ST_IDLE;
                end
                default: state_q <= ebp_pkg::ST_IDLE;
            endcase
        end
    end

    // [R1] [R2] pin drive per nibble role
    always_ff @(posedge clk_link or negedge rstLinkN_q) begin
        if (!rstLinkN_q) begin
            pinOut_q <= ebp_pkg::PIN_RESET;
            pinOe_q <= ebp_pkg::PIN_RESET;
            pinOwned_q <= ebp_pkg::PIN_RESET;
        end else begin
            for (int n = 0; n < ebp_pkg::NIBBLES; n++) begin
                pinOwned_q[4*n +: 4] <= {4{en && role[n][4:3] != ebp_pkg::ROLE_NONE}};
                pinOut_q[4*n +: 4] <= 4'h0;
                pinOe_q[4*n +: 4] <= 4'h0;
                if (en) begin
                    case (role[n][4:3])
                        ebp_pkg::ROLE_ADDR: begin
                            pinOut_q[4*n +: 4] <= aW[{role[n][2:0], 2'b00} +: 4];
                            pinOe_q[4*n +: 4] <= 4'hf;
                        end
                        ebp_pkg::ROLE_DATA: begin
                            pinOut_q[4*n +: 4] <= dW[{role[n][2:0], 2'b00} +: 4];
                            pinOe_q[4*n +: 4] <= {4{inStrb && wrL_q}};
                        end
                        ebp_pkg::ROLE_MUX: begin
                            if (state_q == ebp_pkg::ST_ADDR) begin
                                pinOut_q[4*n +: 4] <= aW[{role[n][2:0], 2'b00} +: 4];
                                pinOe_q[4*n +: 4] <= 4'hf;
                            end else begin
                                pinOut_q[4*n +: 4] <= dW[{role[n][2:0], 2'b00} +: 4];
                                pinOe_q[4*n +: 4] <= {4{inStrb && wrL_q}};
                            end
                        end
                        default: pinOe_q[4*n +: 4] <= 4'h0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_link or negedge rstLinkN_q) begin
        if (!rstLinkN_q) begin
            {busClkOe_q, alStb_q, alStbOe_q, rdOe_q, wrLowOe_q, wrHighOe_q, waitDed_q} <= 7'h00;
            {rdN_q, wrLowN_q, wrHighN_q} <= 3'b111;
        end else begin
            // [R10] clock and read strobe owned whenever enabled
            busClkOe_q <= en;
            rdOe_q <= en;
            rdN_q <= !(en && inStrb && !wrL_q);
            // [R11] [R15] address strobe only on multiplexed buses
            alStbOe_q <= en && !mode[3];
            alStb_q <= en && !mode[3] && state_q == ebp_pkg::ST_ADDR;
            // [R12] [R16] write strobes by bus width and byte lane
            wrLowOe_q <= en;
            wrHighOe_q <= en && mode[2];
            wrLowN_q <= !(en && inStrb && wrL_q && (!mode[2] || beL_q[0]));
            wrHighN_q <= !(en && inStrb && wrL_q && mode[2] && beL_q[1]);
            // [R13] wait pin dedicated as input
            waitDed_q <= en && waitEn;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign extPinOut = pinOut_q;
    assign extPinOe = pinOe_q;
    assign extPinOwned = pinOwned_q;
    assign busClockOutput = busClk_q;
    assign busClockOe = busClkOe_q;
    assign addressLatchStrobe = alStb_q;
    assign addressLatchStrobeOe = alStbOe_q;
    assign readStrobeN = rdN_q;
    assign readStrobeOe = rdOe_q;
    assign writeStrobeLowN = wrLowN_q;
    assign writeStrobeLowOe = wrLowOe_q;
    assign writeStrobeHighN = wrHighN_q;
    assign writeStrobeHighOe = wrHighOe_q;
    assign waitPinDedicated = waitDed_q;

    AST_RELEASE_ALL: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R2]
        !en |=> (pinOe_q == 32'h0000_0000 && pinOwned_q == 32'h0000_0000 && !rdOe_q && !alStbOe_q))
        else $error("pins not released while disabled");
    AST_MODE0_PINS: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R3]
        (en && mode == 4'h0) |=> (pinOwned_q == 32'h0000_00ff))
        else $error("mode zero owns wrong pins");
    AST_MODE3_PINS: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R4]
        (en && mode == 4'h3 && state_q == ebp_pkg::ST_IDLE) |=> (pinOwned_q == 32'h000f_ffff))
        else $error("mode three owns wrong pins");
    AST_CLK_OE: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R10]
        en |=> (busClkOe_q && rdOe_q && wrLowOe_q))
        else $error("clock or read strobe not driven");
    AST_ALS_SEP: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R11]
        mode[3] |=> (!alStbOe_q && !alStb_q))
        else $error("address strobe driven on separate bus");
    AST_WRH_8BIT: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R12]
        !mode[2] |=> (!wrHighOe_q && wrHighN_q))
        else $error("high write strobe used on 8-bit bus");
    AST_WAIT_DED: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R13]
        (en && waitEn) |=> waitDed_q)
        else $error("wait pin not dedicated");
    AST_CLK_HALF: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R14]
        (en && $past(en)) |=> (busClk_q != $past(busClk_q)))
        else $error("bus clock not half rate");
    AST_BYTE_LANE: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R16]
        (en && inStrb && wrL_q && mode[2] && beL_q == 2'b01) |=> (wrHighN_q && !wrLowN_q))
        else $error("wrong lane strobe on byte write");
    AST_WAIT_HOLD: assert property (@(posedge clk_link) disable iff (!rstLinkN_q) // [R17]
        (en && inStrb && tick && waitActive) |=> (inStrb && $stable(addrL_q) && $stable(wdataL_q)))
        else $error("cycle not held during wait");

    CV_WRITE: cover property (@(posedge clk_link) disable iff (!rstLinkN_q)
        inStrb && wrL_q ##[1:8] state_q == ebp_pkg::ST_DONE);
    CV_READ: cover property (@(posedge clk_link) disable iff (!rstLinkN_q)
        inStrb && !wrL_q ##[1:8] state_q == ebp_pkg::ST_DONE);
    CV_WAIT: cover property (@(posedge clk_link) disable iff (!rstLinkN_q)
        inStrb && tick && waitActive);
    CV_APB: cover property (@(posedge clk_sys) disable iff (!resetn) apbWrite && paddr == ebp_pkg::OFF_CMD);
endmodule

/* File: bench/ebp_ext_mem.sv */
// far-side memory model answering bus cycles on the pins
`timescale 1ns/1ps
module ebp_ext_mem (
    input wire logic clk_link,
    input wire logic [31:0] extPinOut,
    input wire logic [31:0] extPinOe,
    input wire logic addressLatchStrobe,
    input wire logic readStrobeN,
    input wire logic busClockOutput,
    input wire logic [3:0] waitLen,
    output logic [31:0] extPinIn,
    output logic waitPinN
);
    logic [7:0] addrQ = 8'h00;
    logic [15:0] lastQ = 16'h0000;
    logic [3:0] tickQ = 4'h0;
    logic [15:0] drv;
    always @(posedge clk_link) begin
        if (addressLatchStrobe) addrQ <= extPinOut[7:0];
        lastQ <= drv;
    end
    // wait low from idle, the block syncs it late; freed after waitLen bus clocks
    always @(posedge clk_link) begin
        if (readStrobeN) tickQ <= 4'h0;
        else if (busClockOutput) tickQ <= tickQ + 4'h1;
    end
    assign waitPinN = (tickQ >= waitLen);
    // released lines show a changing pattern
    assign drv = !readStrobeN ? {~addrQ, addrQ} : ~lastQ;
    assign extPinIn = (extPinOut & extPinOe) | ({~drv, drv} & ~extPinOe);
endmodule

/* File: bench/ebp_ext_bus_test.sv */
// self-checking bench for the external bus pin block
`timescale 1ns/1ps
module ebp_ext_bus_test;
    localparam logic [127:0] NIBS = 128'h00FF_7F3F_7F3F_1F0F_1F0F_0F0F_1F0F_0703;
    logic clk_sys = 1'b0, clk_link = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, pinIn, pinOut, pinOe, owned;
    logic pready, pslverr, bco, bcoOe, als, alsOe, rdN, rdOe, wlN, wlOe, whN, whOe, waitN, waitDed;
    logic lastErr, loSeen = 1'b0, hiSeen = 1'b0;
    logic [7:0] rdLow = 8'h00;
    logic [15:0] wrSeen = 16'h0000;
    logic [3:0] waitLen = 4'h0;
    int n_fail = 0, compares = 0, cyc = 0;
    ebp_ext_bus dut_u (.clk_sys(clk_sys), .resetn(resetn), .clk_link(clk_link), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extPinIn(pinIn), .extPinOut(pinOut), .extPinOe(pinOe), .extPinOwned(owned), .busClockOutput(bco),
        .busClockOe(bcoOe), .addressLatchStrobe(als), .addressLatchStrobeOe(alsOe), .readStrobeN(rdN),
        .readStrobeOe(rdOe), .writeStrobeLowN(wlN), .writeStrobeLowOe(wlOe), .writeStrobeHighN(whN),
        .writeStrobeHighOe(whOe), .waitPinN(waitN), .waitPinDedicated(waitDed));
    ebp_ext_mem mem_u (.clk_link(clk_link), .extPinOut(pinOut), .extPinOe(pinOe), .addressLatchStrobe(als),
        .readStrobeN(rdN), .busClockOutput(bco), .waitLen(waitLen), .extPinIn(pinIn), .waitPinN(waitN));
    always #5 clk_sys = ~clk_sys;
    always #24 clk_link = ~clk_link;
    // pins looked at mid-cycle, away from the edge that launches them
    always @(negedge clk_link) begin
        if (!wlN) loSeen <= 1'b1;
        if (!whN) hiSeen <= 1'b1;
        if (!wlN) wrSeen <= pinOut[15:0] & pinOe[15:0];
        if (!rdN) rdLow <= rdLow + 8'h01;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] expOwned(input logic en, input logic [3:0] m);
        logic [31:0] o;
        for (int i = 0; i < 32; i++) o[i] = en & NIBS[{m, 3'b000} + i / 4];
        return o;
    endfunction
    task automatic cfgChk(input logic en, input logic wen, input logic [3:0] m);
        logic [31:0] r;
        apb(1'b1, ebp_pkg::OFF_CTRL, {24'h00_0000, m, 2'b00, wen, en}, r);
        do begin
            apb(1'b0, ebp_pkg::OFF_STATUS, 32'h0000_0000, r);
        end while (r[1] !== 1'b0);
        repeat (10) @(posedge clk_sys);
        chk(owned, expOwned(en, m));
        chk({waitDed, whOe, wlOe, alsOe, rdOe, bcoOe}, {en & wen, en & m[2], en, en & ~m[3], en, en});
    endtask
    task automatic busOp(input logic [19:0] a, input logic [15:0] wd, input logic [31:0] cmd);
        logic [31:0] r;
        apb(1'b1, ebp_pkg::OFF_ADDR, {12'h000, a}, r);
        apb(1'b1, ebp_pkg::OFF_WDATA, {16'h0000, wd}, r);
        apb(1'b1, ebp_pkg::OFF_CMD, cmd, r);
        do begin
            apb(1'b0, ebp_pkg::OFF_STATUS, 32'h0000_0000, r);
        end while (r[0] !== 1'b0);
    endtask
    // read strobe length with wait held from idle: w bus clocks, two more for the wait sync
    function automatic logic [31:0] expStrobe(input logic [3:0] w);
        return 32'(2 * w + 4);
    endfunction
    initial begin
        logic [31:0] r;
        logic b0;
        logic [19:0] a;
        logic [15:0] wd;
        void'($urandom(22373));
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 15; i++) cfgChk(1'b1, 1'($urandom), 4'(i));
        cfgChk(1'b0, 1'($urandom), 4'($urandom % 15));
        cfgChk(1'b1, 1'b1, 4'h4);
        @(negedge clk_link) b0 = bco;
        @(negedge clk_link) chk({31'h0000_0000, bco ^ b0}, 32'h0000_0001);
        for (int i = 0; i < 3; i++) begin
            a = 20'($urandom);
            waitLen <= 4'(i + 1);
            rdLow = 8'h00;
            busOp(a, 16'($urandom), 32'h0000_000d);
            apb(1'b0, ebp_pkg::OFF_RDATA, 32'h0000_0000, r);
            chk(r, {16'h0000, ~a[7:0], a[7:0]});
            chk({24'h00_0000, rdLow}, expStrobe(4'(i + 1)));
        end
        loSeen = 1'b0;
        hiSeen = 1'b0;
        waitLen <= 4'h0;
        wd = 16'($urandom);
        busOp(20'($urandom), wd, 32'h0000_0007);
        chk({30'h0000_0000, hiSeen, loSeen}, 32'h0000_0001);
        chk({16'h0000, wrSeen}, {16'h0000, wd});
        apb(1'b0, ebp_pkg::OFF_RDATA, 32'h0000_0000, r);
        chk(r, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0000_0000, r);
        chk({r[31:1], lastErr}, 32'h0000_0001);
        stop_test();
    end
endmodule
